// [t8sc_pkg.sv]
// Behaviour
// - Compare flag B, status bit 7, sets when the counter equals constant B.
// - Compare flag A, status bit 6, sets when the counter equals constant A.
// - The wrap flag, status bit 5, sets when the 8-bit counter rolls from its top value to zero.
// - Software clears a status flag by reading it as one and then writing zero to it, and the block obeys that sequence.
// - Status bit 4 and trigger control bits 7 to 5 and 1 always read as one, and writes to them do nothing.
// - On a compare match B the waveform output follows status bits 3:2: keep, low, high or toggle.
// - On a compare match A the waveform output follows status bits 1:0 with the same encoding.
// - After reset the waveform output stays low until the first compare match acts on it.
// - Trigger control bits 4:3 pick the trigger edge: none, rising, falling or both.
// - With trigger enable bit 2 set, a clear halts the counter until the selected trigger edge arrives.
// - With trigger enable clear, the trigger input neither starts nor halts the counter.
// - Trigger control bit 0 joins the three clock-select bits of the main control register to pick the clock.
// - Each internal clock-select code picks one of two prescaler taps from phi/4 to phi/128, counted on the tap's falling edge.
// - An interrupt is raised for each set flag whose enable bit in main control bits 7, 6 or 5 is one.
package t8sc_pkg;

  // ****************************************
  // Register map, byte addresses on the bus.
  // ****************************************
  localparam int          ADDR_W         = 5;
  localparam logic [4:0]  OFF_STATUS     = 5'h00;
  localparam logic [4:0]  OFF_TRIG       = 5'h04;
  localparam logic [4:0]  OFF_MAIN       = 5'h08;
  localparam logic [4:0]  OFF_COUNT      = 5'h0C;
  localparam logic [4:0]  OFF_CONST_A    = 5'h10;
  localparam logic [4:0]  OFF_CONST_B    = 5'h14;
  localparam logic [4:0]  OFF_EVT_STAT   = 5'h18;
  localparam logic [4:0]  OFF_EVT_MASK   = 5'h1C;

  // ****************************************
  // Field positions.
  // ****************************************
  localparam int          BIT_MATCH_B    = 7;
  localparam int          BIT_MATCH_A    = 6;
  localparam int          BIT_WRAP       = 5;
  localparam int          ACT_B_LO       = 2;
  localparam int          ACT_A_LO       = 0;
  localparam int          EDGE_LO        = 3;
  localparam int          BIT_TRG_EN     = 2;
  localparam int          BIT_SUB_SEL    = 0;
  localparam int          CLR_LO         = 3;
  localparam int          CKS_LO         = 0;
  localparam int          FLAG_W         = 3;

  // ****************************************
  // Reset values and fixed-one masks.
  // ****************************************
  localparam logic [7:0]  STATUS_ONES    = 8'h10;
  localparam logic [7:0]  TRIG_ONES      = 8'hE2;
  localparam logic [7:0]  TRIG_WR        = 8'h1D;
  localparam logic [7:0]  MAIN_RST       = 8'h00;
  localparam logic [7:0]  CONST_RST      = 8'hFF;
  localparam logic [7:0]  COUNT_RST      = 8'h00;
  localparam logic [7:0]  COUNT_MAX      = 8'hFF;

  // ****************************************
  // Encodings.
  // ****************************************
  localparam logic [1:0]  ACT_NONE       = 2'h0;
  localparam logic [1:0]  ACT_LOW        = 2'h1;
  localparam logic [1:0]  ACT_HIGH       = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE     = 2'h3;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  localparam logic [1:0]  CLR_BY_A       = 2'h1;
  localparam logic [1:0]  CLR_BY_B       = 2'h2;
  localparam logic [1:0]  CLR_BY_PIN     = 2'h3;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam int          PIN_EXT_CLK    = 0;
  localparam int          PIN_CLR        = 1;
  localparam int          PIN_TRIG       = 2;
  localparam int          SYNC_STAGES    = 3;
  localparam int          DIV_W          = 7;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DATA = 2'b10
  } t8sc_bus_t;

endpackage

// [t8sc_inputs.sv]
// ****************************************
// Pin conditioning and internal prescaler.
// ****************************************
module t8sc_inputs
  import t8sc_pkg::*;
#(
  parameter int N_PIN = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [N_PIN-1:0] pins_in,
  input  wire logic [2:0]       clk_sel,
  input  wire logic             sub_sel,
  output logic      [N_PIN-1:0] pin_rise_q,
  output logic      [N_PIN-1:0] pin_fall_q,
  output logic                  tick_int_q
);

  // Each pin passes three flops; a change counts once stages two and three agree.
  for (genvar i = 0; i < N_PIN; i++) begin : g_pin
    logic [SYNC_STAGES-1:0] sync_q, sync_d;
    logic                   lvl_q, lvl_d;
    logic                   rise_d, fall_d;

    // Next-value logic; the first stage only feeds the second.
    always_comb begin
      sync_d = {sync_q[SYNC_STAGES-2:0], pins_in[i]};
      lvl_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
      rise_d = lvl_d & ~lvl_q;
      fall_d = ~lvl_d & lvl_q;
    end

    // Registers of the conditioned pin.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        // Reset keeps the chain filling and loads the settled level, so a pin idling high gives no false edge.
        sync_q        <= sync_d;
        lvl_q         <= sync_q[SYNC_STAGES-1];
        pin_rise_q[i] <= 1'b0;
        pin_fall_q[i] <= 1'b0;
      end else begin
        sync_q        <= sync_d;
        lvl_q         <= lvl_d;
        pin_rise_q[i] <= rise_d;
        pin_fall_q[i] <= fall_d;
      end
    end
  end

  logic [DIV_W-1:0] div_q, div_d;
  logic             tap_q, tap_d;
  logic             tick_d;
  logic [2:0]       tap_idx;

  // Tap index is 2*(code-1)+sub+1, so code 1 gives phi/4 or phi/8 up to phi/128.
  // A switch between taps from high to low reads as a falling edge and counts once.
  always_comb begin
    div_d   = div_q + 1'b1;
    tap_idx = 3'(({1'b0, clk_sel[1:0]} - 3'd1) * 3'd2 + {2'b00, sub_sel} + 3'd1);
    tap_d   = (clk_sel[2] == 1'b0 && clk_sel[1:0] != 2'b00) ? div_q[tap_idx] : 1'b0;
    tick_d  = tap_q & ~tap_d;
  end

  // Prescaler registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_q      <= '0;
      tap_q      <= 1'b0;
      tick_int_q <= 1'b0;
    end else begin
      div_q      <= div_d;
      tap_q      <= tap_d;
      tick_int_q <= tick_d;
    end
  end

  chk_tick_fall_edge: assert property (@(posedge clk) disable iff (!rst_n)
    tick_int_q |-> $past(tap_q) && !tap_q) else $error("Prescaler tick without falling tap.");

endmodule // t8sc_inputs

// [t8sc_top.sv]
// ****************************************
// Event timer status, output and trigger control.
// ****************************************
module t8sc_top
  import t8sc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        ext_clk_in,
  input  wire logic        counter_reset_in,
  input  wire logic        trigger_in,
  output logic             waveform_out,
  output logic             irq
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Bus slave.
  // ****************************************
  t8sc_bus_t        state_q, state_d;
  logic [4:0]       addr_q, addr_d;
  logic             hit_q, hit_d;
  logic             wr_q, wr_d;
  logic             rdy_d;
  logic             do_rd, do_wr;

  // One wait state lets read data leave a flop; writes commit in the same cycle.
  always_comb begin
    state_d = state_q;
    addr_d  = addr_q;
    hit_d   = hit_q;
    wr_d    = wr_q;
    rdy_d   = hreadyout;
    case (state_q)
      BUS_IDLE: begin
        if (hsel && htrans == HTRANS_NONSEQ && hready) begin
          state_d = BUS_DATA;
          addr_d  = haddr[4:0];
          hit_d   = (haddr[31:ADDR_W] == '0) && (haddr[1:0] == 2'b00);
          wr_d    = hwrite;
          rdy_d   = 1'b0;
        end
      end
      BUS_DATA: begin
        state_d = BUS_IDLE;
        rdy_d   = 1'b1;
      end
      default: begin
        state_d = BUS_IDLE;
        rdy_d   = 1'b1;
      end
    endcase
    do_rd = (state_q == BUS_DATA) && !wr_q && hit_q;
    do_wr = (state_q == BUS_DATA) && wr_q && hit_q;
  end

  // Bus registers; the response is always OKAY.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q   <= BUS_IDLE;
      addr_q    <= '0;
      hit_q     <= 1'b0;
      wr_q      <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      hit_q     <= hit_d;
      wr_q      <= wr_d;
      hreadyout <= rdy_d;
      hresp     <= 1'b0;
    end
  end

  // ****************************************
  // Pin conditioning and prescaler.
  // ****************************************
  logic [2:0] pin_rise, pin_fall;
  logic       tick_int;
  logic [7:0] main_q, main_d;
  logic [7:0] trig_q, trig_d;

  t8sc_inputs #(.N_PIN(3)) u_inputs (
    .clk        (clk),
    .rst_n      (rst_n),
    .pins_in    ({trigger_in, counter_reset_in, ext_clk_in}),
    .clk_sel    (main_q[CKS_LO+:3]),
    .sub_sel    (trig_q[BIT_SUB_SEL]),
    .pin_rise_q (pin_rise),
    .pin_fall_q (pin_fall),
    .tick_int_q (tick_int)
  );

  // ****************************************
  // Counter, flags, output and registers.
  // ****************************************
  logic [7:0]        cnt_q, cnt_d, ca_q, ca_d, cb_q, cb_d;
  logic [FLAG_W-1:0] flag_q, flag_d, arm_q, arm_d, ev_q, ev_d, mask_q, mask_d, set_v, wclr;
  logic [3:0]        act_q, act_d;
  logic              run_q, run_d, wave_d, irq_d;
  logic [7:0]        rd_d;
  logic              tick, count_en, trg_edge, match_a, match_b, clr, wrap;
  logic              wr_cnt, wr_ca, wr_cb, trg_en;
  logic [1:0]        act_a, act_b, act_sel;
  logic [7:0]        wd;

  // Flag vectors are ordered {match B, match A, wrap}, as in status bits 7:5.
  always_comb begin
    wd     = hwdata[7:0];
    trg_en = trig_q[BIT_TRG_EN];
    wr_cnt = do_wr && addr_q == OFF_COUNT;
    wr_ca  = do_wr && addr_q == OFF_CONST_A;
    wr_cb  = do_wr && addr_q == OFF_CONST_B;
    // External clock codes pick an edge; internal codes use the prescaler tick.
    case (main_q[CKS_LO+:3])
      3'b101:  tick = pin_rise[PIN_EXT_CLK];
      3'b110:  tick = pin_fall[PIN_EXT_CLK];
      3'b111:  tick = pin_rise[PIN_EXT_CLK] | pin_fall[PIN_EXT_CLK];
      3'b000, 3'b100: tick = 1'b0;
      default: tick = tick_int;
    endcase
    count_en = tick && (run_q || !trg_en);
    // Match fires at the count edge, the last state holding the equal value.
    // A constant write in the same cycle inhibits its match.
    match_a = count_en && cnt_q == ca_q && !wr_ca;
    match_b = count_en && cnt_q == cb_q && !wr_cb;
    case (main_q[CLR_LO+:2])
      CLR_BY_A:   clr = match_a;
      CLR_BY_B:   clr = match_b;
      CLR_BY_PIN: clr = pin_rise[PIN_CLR];
      default:    clr = 1'b0;
    endcase
    wrap = count_en && cnt_q == COUNT_MAX && !clr && !wr_cnt;
    // A clear beats a write, and a write beats an increment.
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = COUNT_RST;
    end else if (wr_cnt) begin
      cnt_d = wd;
    end else if (count_en) begin
      cnt_d = cnt_q + 8'h01;
    end
    // Trigger edge selection and halt on clear.
    case (trig_q[EDGE_LO+:2])
      EDGE_RISE: trg_edge = pin_rise[PIN_TRIG];
      EDGE_FALL: trg_edge = pin_fall[PIN_TRIG];
      EDGE_BOTH: trg_edge = pin_rise[PIN_TRIG] | pin_fall[PIN_TRIG];
      default:   trg_edge = 1'b0;
    endcase
    run_d = run_q;
    if (!trg_en) begin
      run_d = 1'b1;
    end else if (clr) begin
      run_d = 1'b0;
    end else if (trg_edge) begin
      run_d = 1'b1;
    end
    // Flags: set wins over the read-then-write-zero clear.
    set_v = {match_b, match_a, wrap};
    arm_d = arm_q;
    wclr  = '0;
    if (do_rd && addr_q == OFF_STATUS) begin
      arm_d = flag_q;
    end
    if (do_wr && addr_q == OFF_STATUS) begin
      wclr  = arm_q & ~wd[BIT_WRAP+:FLAG_W];
      arm_d = '0;
    end
    flag_d = set_v | (flag_q & ~wclr);
    // Sticky event copies for the masked interrupt, cleared by writing one.
    ev_d = ev_q;
    if (do_wr && addr_q == OFF_EVT_STAT) begin
      ev_d = ev_q & ~wd[FLAG_W-1:0];
    end
    ev_d   = ev_d | set_v;
    mask_d = (do_wr && addr_q == OFF_EVT_MASK) ? wd[FLAG_W-1:0] : mask_q;
    act_d  = (do_wr && addr_q == OFF_STATUS) ? wd[3:0] : act_q;
    trig_d = (do_wr && addr_q == OFF_TRIG) ? ((wd & TRIG_WR) | TRIG_ONES) : trig_q;
    main_d = (do_wr && addr_q == OFF_MAIN) ? wd : main_q;
    ca_d   = wr_ca ? wd : ca_q;
    cb_d   = wr_cb ? wd : cb_q;
    // Coincident matches: toggle beats high beats low, which is the larger code.
    act_a   = match_a ? act_q[ACT_A_LO+:2] : ACT_NONE;
    act_b   = match_b ? act_q[ACT_B_LO+:2] : ACT_NONE;
    act_sel = (act_a > act_b) ? act_a : act_b;
    case (act_sel)
      ACT_LOW:    wave_d = 1'b0;
      ACT_HIGH:   wave_d = 1'b1;
      ACT_TOGGLE: wave_d = ~waveform_out;
      default:    wave_d = waveform_out;
    endcase
    irq_d = |(flag_q & main_q[BIT_WRAP+:FLAG_W]) | |(ev_q & mask_q);
    // Read data; unmapped words read as zero.
    case (addr_q)
      OFF_STATUS:   rd_d = {flag_q, 1'b0, act_q} | STATUS_ONES;
      OFF_TRIG:     rd_d = trig_q;
      OFF_MAIN:     rd_d = main_q;
      OFF_COUNT:    rd_d = cnt_q;
      OFF_CONST_A:  rd_d = ca_q;
      OFF_CONST_B:  rd_d = cb_q;
      OFF_EVT_STAT: rd_d = {5'h00, ev_q};
      OFF_EVT_MASK: rd_d = {5'h00, mask_q};
      default:      rd_d = 8'h00;
    endcase
  end

  // Core registers; the waveform output starts low.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q        <= COUNT_RST;
      ca_q         <= CONST_RST;
      cb_q         <= CONST_RST;
      flag_q       <= '0;
      arm_q        <= '0;
      ev_q         <= '0;
      mask_q       <= '0;
      act_q        <= '0;
      trig_q       <= TRIG_ONES;
      main_q       <= MAIN_RST;
      run_q        <= 1'b1;
      waveform_out <= 1'b0;
      irq          <= 1'b0;
      hrdata       <= '0;
    end else begin
      cnt_q        <= cnt_d;
      ca_q         <= ca_d;
      cb_q         <= cb_d;
      flag_q       <= flag_d;
      arm_q        <= arm_d;
      ev_q         <= ev_d;
      mask_q       <= mask_d;
      act_q        <= act_d;
      trig_q       <= trig_d;
      main_q       <= main_d;
      run_q        <= run_d;
      waveform_out <= wave_d;
      irq          <= irq_d;
      hrdata       <= do_rd ? {24'h00_0000, rd_d} : 32'h0000_0000;
    end
  end

  // ****************************************
  // Checks.
  // ****************************************
  chk_match_b_flag: assert property (
    match_b |=> flag_q[2]) else $error("Match B did not set its flag.");
  chk_match_a_flag: assert property (
    match_a |=> flag_q[1]) else $error("Match A did not set its flag.");
  chk_wrap_flag_set: assert property (
    wrap |=> flag_q[0] && cnt_q == COUNT_RST) else $error("Wrap did not set its flag.");
  chk_flag_read_clear: assert property (
    do_wr && addr_q == OFF_STATUS && arm_q[1] && !wd[BIT_MATCH_A] && !match_a |=> !flag_q[1])
    else $error("Armed zero write did not clear flag A.");
  chk_flag_keep_one: assert property (
    do_wr && addr_q == OFF_STATUS && wd[7:5] == 3'b111 && set_v == '0 |=> flag_q == $past(flag_q))
    else $error("Writing ones changed a flag.");
  chk_reserved_ones: assert property (
    do_rd && addr_q == OFF_TRIG |=> hreadyout && hrdata[7:5] == 3'b111 && hrdata[1])
    else $error("Reserved bits did not read as one.");
  chk_wave_b_high: assert property (
    match_b && !match_a && act_q[3:2] == ACT_HIGH |=> waveform_out) else $error("Match B high action failed.");
  chk_wave_a_toggle: assert property (
    match_a && !match_b && act_q[1:0] == ACT_TOGGLE |=> waveform_out != $past(waveform_out))
    else $error("Match A toggle action failed.");
  chk_wave_hold: assert property (
    !match_a && !match_b |=> $stable(waveform_out)) else $error("Waveform changed without a match.");
  chk_halt_on_clear: assert property (
    trg_en && clr ##1 !trg_edge && trg_en |=> !run_q) else $error("Counter kept running after a clear.");
  chk_trig_disabled: assert property (
    !trg_en |=> run_q) else $error("Trigger disabled but counter halted.");
  chk_irq_enable: assert property (
    |(flag_q & main_q[7:5]) |=> irq) else $error("Enabled flag raised no interrupt.");

endmodule // t8sc_top

// [t8sc_ahb_master.sv]
// ****************************************
// Bus master model standing in for the CPU.
// ****************************************
module t8sc_ahb_master
  import t8sc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bus is idle from time zero so that nothing is taken during reset.
  initial begin
    hsel   = 1'h0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // One single word transfer; each phase is held until ready is sampled high.
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    hsel   <= 1'h1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {27'h000_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, (wr ? d : 8'h00)};
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata[7:0];
  endtask
endmodule // t8sc_ahb_master

// [test_t8sc_top.sv]
// ****************************************
// Self-checking bench for the timer control block.
// ****************************************
module test_t8sc_top
  import t8sc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'h0;
  logic        rst_n, hsel, hwrite, hreadyout, hresp, trigger_in, waveform_out, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  q;
  logic        ext_clk     = 1'h0;
  logic        counter_clr = 1'h0;
  int          n_errors = 0;
  int          samples_checked = 0;

  // The external clock and clear pins idle low until their own scenarios drive them.
  t8sc_top t8sc_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .ext_clk_in(ext_clk), .counter_reset_in(counter_clr),
    .trigger_in(trigger_in), .waveform_out(waveform_out), .irq(irq));
  t8sc_ahb_master t8sc_ahb_master_i (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // Free running system clock of 4 ns.
  always #2 clk = ~clk;

  // ****************************************
  // Helper tasks.
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] unused;
    t8sc_ahb_master_i.xfer(1'h1, a, d, unused);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    t8sc_ahb_master_i.xfer(1'h0, a, 8'h00, d);
  endtask

  task automatic expect_rd(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  // Polling a flag reads the status, which also arms it for a later clear.
  task automatic poll(input int b);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 400 && s[b] !== 1'h1; k++) rd(OFF_STATUS, s);
    chk1(s[b], 1'h1);
  endtask

  // The interrupt is registered behind the flags, so give it a few edges.
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Cuts a hang short well past the expected length of the run.
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end

  // ****************************************
  // Test sequence.
  // ****************************************
  localparam logic [4:0] RA [7] = '{OFF_STATUS, OFF_TRIG, OFF_MAIN, OFF_COUNT, OFF_CONST_A, OFF_CONST_B, 5'h02};
  localparam logic [7:0] RV [7] = '{8'h10, 8'hE2, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00};
  localparam logic [1:0] ACTS [4] = '{ACT_HIGH, ACT_LOW, ACT_TOGGLE, ACT_NONE};
  localparam logic       WF [4] = '{1'h1, 1'h0, 1'h1, 1'h1};
  localparam logic [1:0] EDG [4] = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_RISE};
  localparam logic       LV0 [4] = '{1'h0, 1'h1, 1'h0, 1'h1};
  localparam logic       RUN [4] = '{1'h1, 1'h1, 1'h1, 1'h0};

  initial begin
    rst_n = 1'h0;
    trigger_in = 1'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    // Reset values, including an unaligned place that reads as zero.
    for (int i = 0; i < 7; i++) expect_rd(RA[i], RV[i]);
    chk1(waveform_out, 1'h0);
    chk1(irq, 1'h0);
    chk1(hresp, 1'h0);
    // Fixed-one bits ignore writes of either level.
    wr(OFF_TRIG, 8'h00);
    expect_rd(OFF_TRIG, 8'hE2);
    wr(OFF_TRIG, 8'hFF);
    expect_rd(OFF_TRIG, 8'hFF);
    wr(OFF_TRIG, 8'h00);
    wr(OFF_STATUS, 8'h00);
    expect_rd(OFF_STATUS, 8'h10);
    // Each match A action in turn; the long period keeps one match per poll.
    wr(OFF_CONST_A, 8'h40);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_MAIN, 8'h00);
      wr(OFF_COUNT, 8'h00);
      rd(OFF_STATUS, q);
      wr(OFF_STATUS, {6'h04, ACTS[i]});
      expect_rd(OFF_STATUS, {6'h04, ACTS[i]});
      wr(OFF_MAIN, 8'h09);
      poll(BIT_MATCH_A);
      chk1(waveform_out, WF[i]);
    end
    // Wrap past constant B with a low action on match B.
    wr(OFF_MAIN, 8'h00);
    wr(OFF_COUNT, 8'hFE);
    rd(OFF_STATUS, q);
    wr(OFF_STATUS, 8'h04);
    wr(OFF_EVT_STAT, 8'h07);
    wr(OFF_EVT_MASK, 8'h00);
    wr(OFF_MAIN, 8'h21);
    poll(BIT_WRAP);
    wr(OFF_MAIN, 8'h20);
    expect_rd(OFF_STATUS, 8'hB4);
    chk1(waveform_out, 1'h0);
    settle();
    chk1(irq, 1'h1);
    wr(OFF_MAIN, 8'h00);
    settle();
    chk1(irq, 1'h0);
    wr(OFF_EVT_MASK, 8'h01);
    settle();
    chk1(irq, 1'h1);
    expect_rd(OFF_EVT_STAT, 8'h05);
    wr(OFF_EVT_STAT, 8'h07);
    expect_rd(OFF_EVT_STAT, 8'h00);
    settle();
    chk1(irq, 1'h0);
    // Writing ones, then zero after a disarming write, keeps the flags.
    wr(OFF_STATUS, 8'hB4);
    wr(OFF_STATUS, 8'h04);
    expect_rd(OFF_STATUS, 8'hB4);
    wr(OFF_STATUS, 8'h04);
    expect_rd(OFF_STATUS, 8'h14);
    // Every internal tap; tolerance covers start, stop and a switching count.
    for (int i = 0; i < 6; i++) begin
      wr(OFF_TRIG, {7'h00, i[0]});
      wr(OFF_COUNT, 8'h00);
      wr(OFF_MAIN, {5'h00, 3'(i / 2 + 1)});
      repeat (512) @(posedge clk);
      wr(OFF_MAIN, 8'h00);
      rd(OFF_COUNT, q);
      chk1(int'(q) >= (128 >> (i)) - 1 && int'(q) <= (130 >> (i)) + 2, 1'h1);
    end
    // Halt after a match clear, then restart only on the selected edge.
    for (int i = 0; i < 4; i++) begin
      wr(OFF_MAIN, 8'h00);
      wr(OFF_TRIG, 8'h00);
      trigger_in <= LV0[i];
      wr(OFF_COUNT, 8'h00);
      wr(OFF_TRIG, {3'h0, EDG[i], 3'h4});
      wr(OFF_MAIN, 8'h09);
      repeat (400) @(posedge clk);
      expect_rd(OFF_COUNT, 8'h00);
      trigger_in <= ~LV0[i];
      repeat (40) @(posedge clk);
      rd(OFF_COUNT, q);
      chk1(q != 8'h00, RUN[i]);
    end
    // With the trigger disabled the halted counter runs again without an edge.
    wr(OFF_TRIG, 8'h08);
    repeat (40) @(posedge clk);
    rd(OFF_COUNT, q);
    chk1(q != 8'h00, 1'h1);
    // External count pin on rising edges, then on both; slow enough for the synchroniser.
    for (int i = 0; i < 2; i++) begin
      wr(OFF_MAIN, 8'h00);
      wr(OFF_COUNT, 8'h00);
      wr(OFF_MAIN, i ? 8'h07 : 8'h05);
      repeat (10) begin
        repeat (8) @(posedge clk);
        ext_clk <= ~ext_clk;
      end
      repeat (8) @(posedge clk);
      expect_rd(OFF_COUNT, i ? 8'h0A : 8'h05);
    end
    // The clear pin empties a stopped counter on its rising edge.
    wr(OFF_COUNT, 8'h33);
    wr(OFF_MAIN, 8'h18);
    counter_clr <= 1'h1;
    repeat (8) @(posedge clk);
    expect_rd(OFF_COUNT, 8'h00);
    report_and_stop();
  end
endmodule // test_t8sc_top
